// ===== design/edge_timer.sv
// up counter that flags expiry after a programmable number of cycles
`timescale 1ns/1ps
`default_nettype none
module edge_timer #(
  parameter int unsigned W = 24
) (
  input wire logic clk,             // system clock
  input wire logic srst,            // synchronous reset
  input wire logic run,             // count while high, reload when low
  input wire logic [W-1:0] limit,   // cycles allowed
  output logic expired              // limit reached while running
);
  logic [W-1:0] cnt_ff;

  // count up while running, clear when idle
  always_ff @(posedge clk)
  begin
    if (srst || !run)
      cnt_ff <= '0;
    else if (!expired)
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
  end

  assign expired = run && (cnt_ff >= limit);
endmodule : edge_timer
`default_nettype wire

// ===== design/tray_lift_and_jam_monitor.sv
// lifter motor control and jam detection for one paper tray
`timescale 1ns/1ps
`default_nettype none
module tray_lift_and_jam_monitor #(
  parameter int unsigned CW = 24
) (
  input wire logic SYS_CLK,                      // 100 MHz clock
  input wire logic SRST,                         // sync reset, active high
  input wire tray_lift_pkg::sense_type SENSE,    // tray sensors
  input wire logic PRINTING,                     // print job active
  input wire logic PICK_REQ,                     // pulse: pick one sheet
  input wire logic DELIVERY_DONE,                // pulse: auto delivery over
  input wire logic FAULT_CLR,                    // pulse: clear jam flags
  input wire logic [CW-1:0] LIFT_LIMIT,          // lifter timeout cycles
  input wire logic [CW-1:0] PICK_LIMIT,          // leading-edge timeout
  output logic LIFT_MOTOR_UP,                    // lifter motor raise
  output logic PICK_SOLENOID,                    // pickup solenoid on
  output logic FEED_BUSY,                        // feed operation running
  output tray_lift_pkg::fault_type FAULTS        // flags to the controller
);
  import tray_lift_pkg::*;

  typedef enum logic [1:0] {
    LIFT_IDLE = 2'b00,
    LIFT_RUN = 2'b01,
    LIFT_FAIL = 2'b10
  } lift_state_type;

  typedef enum logic [1:0] {
    PICK_IDLE = 2'b00,
    PICK_WAIT = 2'b01,
    PICK_FEED = 2'b10
  } pick_state_type;

  lift_state_type lift_ff, nxt_lift;
  pick_state_type pick_ff, nxt_pick;
  logic first_ff, cass_ff, door_ff, surf_ff, motor_ff, sol_ff;
  logic [1:0] tries_ff;
  logic lift_to, pick_to, trigger, retry_ff, pick_miss;
  fault_type fault_ff;

  // remember previous sensor levels for edge detection
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      first_ff <= 1'b1;
      cass_ff <= 1'b0;
      door_ff <= 1'b0;
      surf_ff <= 1'b0;
    end
    else
    begin
      first_ff <= 1'b0;
      cass_ff <= SENSE.cassette;
      door_ff <= SENSE.door_open;
      surf_ff <= SENSE.surface;
    end
  end

  // power-on, insertion or stack drop while printing start a lift-up cycle
  assign trigger = first_ff || (SENSE.cassette && !cass_ff)
    || (surf_ff && !SENSE.surface && PRINTING);

  // lifter sequence
  always_comb
  begin
    nxt_lift = lift_ff;
    case (lift_ff)
      LIFT_IDLE:
        if (SENSE.cassette && !SENSE.surface && trigger)
          nxt_lift = LIFT_RUN;
      LIFT_RUN:
        if (!SENSE.cassette)
          nxt_lift = LIFT_IDLE;
        else if (SENSE.surface)
          nxt_lift = LIFT_IDLE;
        else if (lift_to)
          nxt_lift = LIFT_FAIL;
      LIFT_FAIL:
        if (trigger && SENSE.cassette)
          nxt_lift = SENSE.surface ? LIFT_IDLE : LIFT_RUN;
      default:
        nxt_lift = LIFT_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      lift_ff <= LIFT_IDLE;
    else
      lift_ff <= nxt_lift;
  end

  // motor raises only in a running cycle with the tray present
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      motor_ff <= 1'b0;
    else
      motor_ff <= (nxt_lift == LIFT_RUN);
  end

  edge_timer #(.W(CW)) u_lift_timer (
    .clk(SYS_CLK),
    .srst(SRST),
    .run(lift_ff == LIFT_RUN),
    .limit(LIFT_LIMIT),
    .expired(lift_to)
  );

  edge_timer #(.W(CW)) u_pick_timer (
    .clk(SYS_CLK),
    .srst(SRST),
    .run(pick_ff == PICK_WAIT),
    .limit(PICK_LIMIT),
    .expired(pick_to)
  );

  // timeout with no sheet edge and door shut: one failed attempt
  assign pick_miss = pick_ff == PICK_WAIT && pick_to && !SENSE.media
    && !SENSE.door_open;

  // pickup sequence: solenoid on, wait for leading edge, one retry
  always_comb
  begin
    nxt_pick = pick_ff;
    case (pick_ff)
      PICK_IDLE:
        if ((PICK_REQ || retry_ff) && !SENSE.door_open
          && !fault_ff.pick_jam)
          nxt_pick = PICK_WAIT;
      PICK_WAIT:
        if (SENSE.door_open)
          nxt_pick = PICK_IDLE;
        else if (SENSE.media)
          nxt_pick = PICK_FEED;
        else if (pick_to)
          nxt_pick = PICK_IDLE;
      PICK_FEED:
        if (!SENSE.media || SENSE.door_open)
          nxt_pick = PICK_IDLE;
      default:
        nxt_pick = PICK_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      pick_ff <= PICK_IDLE;
    else
      pick_ff <= nxt_pick; // one idle cycle reloads the timer
  end

  // attempt counter and solenoid drive
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      tries_ff <= 2'h0;
      sol_ff <= 1'b0;
    end
    else
    begin
      if (pick_ff == PICK_IDLE && PICK_REQ && !retry_ff)
        tries_ff <= 2'h1;
      else if (pick_miss && tries_ff != PICK_TRIES)
        tries_ff <= tries_ff + 2'h1;
      sol_ff <= (nxt_pick == PICK_WAIT);
    end
  end

  // retry: after first timeout start again automatically
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      retry_ff <= 1'b0;
    else
      retry_ff <= pick_miss && tries_ff != PICK_TRIES;
  end

  // jam flags sticky until FAULT_CLR, lift_fail held only while in LIFT_FAIL; a set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      fault_ff <= '0;
    else
    begin
      if (lift_ff == LIFT_RUN && nxt_lift == LIFT_FAIL)
        fault_ff.lift_fail <= 1'b1;
      else if (nxt_lift != LIFT_FAIL)
        fault_ff.lift_fail <= 1'b0;
      if (pick_miss && tries_ff == PICK_TRIES)
        fault_ff.pick_jam <= 1'b1;
      else if (FAULT_CLR)
        fault_ff.pick_jam <= 1'b0;
      if (SENSE.media && (first_ff || (door_ff && !SENSE.door_open)
        || DELIVERY_DONE))
        fault_ff.residual_jam <= 1'b1;
      else if (FAULT_CLR)
        fault_ff.residual_jam <= 1'b0;
      if (SENSE.door_open && FEED_BUSY)
        fault_ff.door_jam <= 1'b1;
      else if (FAULT_CLR)
        fault_ff.door_jam <= 1'b0;
    end
  end

  assign LIFT_MOTOR_UP = motor_ff;
  assign PICK_SOLENOID = sol_ff;
  assign FEED_BUSY = (pick_ff != PICK_IDLE) || retry_ff;
  assign FAULTS = fault_ff;

  AST_MOTOR_STOP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    SENSE.surface && lift_ff == LIFT_RUN |=> !LIFT_MOTOR_UP)
    else $error("motor still running after surface seen");
  AST_POWER_LIFT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $fell(first_ff) && SENSE.cassette && !SENSE.surface
    |-> LIFT_MOTOR_UP)
    else $error("no lift after power-on");
  AST_LIFT_FAIL: assert property (@(posedge SYS_CLK) disable iff (SRST)
    lift_ff == LIFT_RUN && lift_to && SENSE.cassette && !SENSE.surface
    |=> FAULTS.lift_fail && !LIFT_MOTOR_UP)
    else $error("lifter timeout not flagged");
  AST_HOLD_OFF: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !SENSE.cassette |=> !LIFT_MOTOR_UP)
    else $error("motor runs without cassette");
  AST_DOOR_JAM: assert property (@(posedge SYS_CLK) disable iff (SRST)
    SENSE.door_open && FEED_BUSY |=> FAULTS.door_jam)
    else $error("door jam missed");
  AST_PICK_JAM: assert property (@(posedge SYS_CLK) disable iff (SRST)
    pick_miss && tries_ff == PICK_TRIES
    |=> FAULTS.pick_jam && !PICK_SOLENOID)
    else $error("pickup jam missed");
  AST_RESIDUAL: assert property (@(posedge SYS_CLK) disable iff (SRST)
    SENSE.media && DELIVERY_DONE |=> FAULTS.residual_jam)
    else $error("residual jam missed");
  AST_REFALL: assert property (@(posedge SYS_CLK) disable iff (SRST)
    lift_ff == LIFT_IDLE && PRINTING && SENSE.cassette
    && $fell(SENSE.surface) |=> LIFT_MOTOR_UP)
    else $error("no relift on stack drop");
  AST_SENSE: assert property (@(posedge SYS_CLK) disable iff (SRST)
    pick_ff == PICK_WAIT && SENSE.media && !SENSE.door_open
    |=> pick_ff == PICK_FEED)
    else $error("leading edge not taken");
  AST_LIMITS: assert property (@(posedge SYS_CLK) disable iff (SRST)
    pick_to |-> tries_ff != 2'h0)
    else $error("timeout with no attempt");

  COV_LIFT: cover property (@(posedge SYS_CLK) $fell(LIFT_MOTOR_UP));
  COV_FAIL: cover property (@(posedge SYS_CLK) $rose(FAULTS.lift_fail));
  COV_RETRY: cover property (@(posedge SYS_CLK) retry_ff);
  COV_JAM: cover property (@(posedge SYS_CLK) $rose(FAULTS.pick_jam));
endmodule : tray_lift_and_jam_monitor
`default_nettype wire

// ===== design/tray_lift_pkg.sv
// shared constants and carrier types for the tray lift and jam monitor
package tray_lift_pkg;
  localparam int unsigned CNT_W = 24;
  localparam logic [23:0] LIFT_LIMIT_RST = 24'h0f4240; // default lift limit
  localparam logic [23:0] PICK_LIMIT_RST = 24'h00c350; // default edge limit
  localparam logic [1:0] PICK_TRIES = 2'h2; // first try plus one retry

  // sensor inputs of the tray
  typedef struct packed {
    logic surface;   // stack top at pickup position
    logic cassette;  // cassette installed
    logic media;     // media feed sensor sees paper
    logic door_open; // door switch open
  } sense_type;

  // jam and fault flags reported upstream
  typedef struct packed {
    logic lift_fail;
    logic pick_jam;
    logic residual_jam;
    logic door_jam;
  } fault_type;
endpackage : tray_lift_pkg

// ===== tb/tray_lift_and_jam_monitor_tb_top.sv
// self-checking bench for the tray lift and jam monitor
`timescale 1ns/1ps
`default_nettype none
module tray_lift_and_jam_monitor_tb_top;
  import tray_lift_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic cas = 1'b1;
  logic door = 1'b0;
  logic med_f = 1'b1;
  logic drop = 1'b0;
  logic printing = 1'b0;
  logic pick_req = 1'b0;
  logic dlv = 1'b0;
  logic fclr = 1'b0;
  logic [7:0] lift_dly = 8'h05;
  logic [7:0] pick_dly = 8'h03;
  logic surf, med_m, motor, sol, busy;
  logic sol_q = 1'b0;
  sense_type sense;
  fault_type flt;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int rises = 0;
  int n;
  assign sense = {surf, cas, med_m | med_f, door};
  // clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  tray_lift_and_jam_monitor #(.CW(24)) u_dut (
    .SYS_CLK(sys_clk), .SRST(srst), .SENSE(sense), .PRINTING(printing),
    .PICK_REQ(pick_req), .DELIVERY_DONE(dlv), .FAULT_CLR(fclr),
    .LIFT_LIMIT(24'h00001e), .PICK_LIMIT(24'h000014),
    .LIFT_MOTOR_UP(motor), .PICK_SOLENOID(sol), .FEED_BUSY(busy),
    .FAULTS(flt));
  tray_mech_model u_mech (
    .clk(sys_clk), .motor_up(motor), .solenoid(sol), .drop(drop),
    .lift_dly(lift_dly), .pick_dly(pick_dly), .surface(surf),
    .media(med_m));
  task automatic stop_test();
    $display("checks=%0d errors=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cy(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cy
  task automatic pulse(ref logic s);
    s = 1'b1;
    cy(1);
    s = 1'b0;
  endtask : pulse
  // solenoid starts and run limit
  always @(posedge sys_clk)
  begin
    sol_q <= sol;
    if (sol && !sol_q)
      rises <= rises + 1;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    cy(10);
    srst = 1'b0;
    cy(3);
    chk({7'h0, motor}, 8'h01);
    chk({4'h0, flt}, 8'h02);
    cy(15);
    chk({6'h0, motor, surf}, 8'h01);
    med_f = 1'b0;
    pulse(fclr);
    pulse(pick_req);
    cy(1);
    chk({6'h0, sol, busy}, 8'h03);
    cy(15);
    chk({3'h0, sol, busy, flt}, 8'h00);
    pick_dly = 8'h00;
    n = rises;
    pulse(pick_req);
    cy(70);
    chk({3'h0, sol, flt}, 8'h04);
    chk(8'(rises - n), 8'h02);
    pulse(pick_req);
    cy(2);
    chk({7'h0, sol}, 8'h00);
    pulse(fclr);
    pulse(pick_req);
    cy(5);
    door = 1'b1;
    cy(3);
    chk({3'h0, sol, flt}, 8'h01);
    pulse(fclr);
    cy(3);
    chk({4'h0, flt}, 8'h00);
    med_f = 1'b1;
    door = 1'b0;
    cy(3);
    chk({4'h0, flt}, 8'h02);
    med_f = 1'b0;
    pulse(fclr);
    med_f = 1'b1;
    pulse(dlv);
    cy(3);
    chk({4'h0, flt}, 8'h02);
    med_f = 1'b0;
    pulse(fclr);
    printing = 1'b1;
    pulse(drop);
    cy(3);
    chk({7'h0, motor}, 8'h01);
    cy(15);
    chk({6'h0, motor, surf}, 8'h01);
    lift_dly = 8'h00;
    pulse(drop);
    cy(40);
    chk({3'h0, motor, flt}, 8'h08);
    pulse(fclr);
    cy(10);
    chk({3'h0, motor, flt}, 8'h08);
    cas = 1'b0;
    cy(3);
    chk({7'h0, motor}, 8'h00);
    lift_dly = 8'h04;
    cas = 1'b1;
    cy(3);
    chk({3'h0, motor, flt}, 8'h10);
    cy(15);
    chk({6'h0, motor, surf}, 8'h01);
    stop_test();
  end
endmodule : tray_lift_and_jam_monitor_tb_top
`default_nettype wire

// ===== tb/tray_mech_model.sv
// tray mechanics model: stack surface and sheet arrival
`timescale 1ns/1ps
`default_nettype none
module tray_mech_model (
  input wire logic clk,            // system clock
  input wire logic motor_up,       // lifter raising
  input wire logic solenoid,       // pickup solenoid on
  input wire logic drop,           // stack top falls
  input wire logic [7:0] lift_dly, // raise cycles, 0 never
  input wire logic [7:0] pick_dly, // pick cycles, 0 never
  output logic surface,            // stack top seen
  output logic media               // sheet at feed sensor
);
  logic surf_ff = 1'b0;
  logic [7:0] lcnt = 8'h00;
  logic [7:0] pcnt = 8'h00;
  logic [1:0] pass = 2'h0;
  // the stack only rises while the motor turns
  always_ff @(posedge clk)
  begin
    lcnt <= motor_up ? lcnt + 8'h01 : 8'h00;
    if (drop)
      surf_ff <= 1'b0;
    else if (motor_up && lift_dly != 8'h00 && lcnt >= lift_dly)
      surf_ff <= 1'b1;
  end
  // a picked sheet covers the sensor for three cycles
  always_ff @(posedge clk)
  begin
    pcnt <= solenoid ? pcnt + 8'h01 : 8'h00;
    if (solenoid && pick_dly != 8'h00 && pcnt == pick_dly)
      pass <= 2'h3;
    else if (pass != 2'h0)
      pass <= pass - 2'h1;
  end
  assign surface = surf_ff;
  assign media = (pass != 2'h0);
endmodule : tray_mech_model
`default_nettype wire
